// *** core/rhw_host_port.sv ***
`timescale 1ns/10ps
`include "rhw_map.svh"

module rhw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wptr, rptr, next_wptr, next_rptr;
   logic push, pop;

   // Full when pointers differ only in the wrap bit
   always_comb begin
      in_ready_out = (wptr ^ rptr) != {1'b1, {AW{1'b0}}};
      out_valid_out = wptr != rptr;
      out_data_out = mem[rptr[AW-1:0]];
      push = in_valid_in & in_ready_out;
      pop = out_valid_out & out_ready_in;
      next_wptr = wptr + (AW+1)'(push);
      next_rptr = rptr + (AW+1)'(pop);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
      end
      if (push) begin
         mem[wptr[AW-1:0]] <= in_data_in;
      end
   end
endmodule : rhw_fifo

module rhw_host_port #(
   parameter int QUEUE_DEPTH = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic chip_enable_in,
   input wire logic link_clk_in,
   input wire logic [7:0] bus_in,
   output logic [7:0] bus_out,
   output logic [7:0] bus_oe_n_out,
   output logic wr_strobe_out,
   output rhw_pkg::rhw_wr_t wr_out,
   output logic cmd_strobe_out,
   output logic [4:0] cmd_code_out,
   output logic rd_req_out,
   output rhw_pkg::rhw_loc_t rd_loc_out,
   input wire logic [7:0] rd_data_in,
   output logic queue_valid_out,
   output logic [7:0] queue_data_out,
   input wire logic queue_ready_in,
   output logic queue_space_out,
   output logic queue_overflow_out,
   output logic direct_exit_out,
   output logic serial_mode_out,
   output logic mode_locked_out,
   output logic busy_out
);
   import rhw_pkg::*;

   // Two-stage synchronisers, third stage for edges
   logic [9:0] sync1, sync2;
   logic en_d, clk_d, top_d, sel_d;
   always_ff @(posedge clk_in) begin
      sync1 <= {chip_enable_in, link_clk_in, bus_in};
      sync2 <= sync1;
      en_d <= sync2[9];
      clk_d <= sync2[8];
      top_d <= sync2[`RHW_PIN_SDI];
      sel_d <= sync2[`RHW_PIN_SEL];
   end

   logic en_s, lclk, top, sel;
   logic [7:0] bus_s;
   logic clk_rise, clk_fall, top_rise, top_fall, sel_rise, sel_fall;
   assign en_s = sync2[9];
   assign lclk = sync2[8];
   assign bus_s = sync2[7:0];
   assign top = bus_s[`RHW_PIN_SDI];
   assign sel = bus_s[`RHW_PIN_SEL];
   assign clk_rise = lclk & ~clk_d;
   assign clk_fall = ~lclk & clk_d;
   assign top_rise = top & ~top_d;
   assign top_fall = ~top & top_d;
   assign sel_rise = sel & ~sel_d;
   assign sel_fall = ~sel & sel_d;

   // Front end registers: mode, burst-stop arm, serial shifter
   logic serial, locked, arm, next_serial, next_locked, next_arm;
   logic [7:0] sh_in, next_sh_in;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic start_evt, sstop_evt, bstop_evt, byte_evt, driving;
   logic [7:0] byte_val;

   // Start and single-stop conditions are ignored while we drive the bus ourselves
   assign driving = ~bus_oe_n_out[`RHW_PIN_SDI];

   always_comb begin
      next_serial = serial;
      next_locked = locked;
      next_arm = arm;
      next_sh_in = sh_in;
      next_bit_cnt = bit_cnt;
      start_evt = 1'b0;
      sstop_evt = 1'b0;
      bstop_evt = 1'b0;
      byte_evt = 1'b0;
      byte_val = bus_s;
      if (!locked) begin
         if (en_s & ~en_d) begin
            next_serial = |bus_s;
            next_locked = 1'b1;
         end
      end else if (!serial) begin
         start_evt = top_rise & lclk & clk_d & ~driving;
         sstop_evt = top_fall & lclk & clk_d & ~driving;
         bstop_evt = top_fall & ~lclk & arm;
         if (clk_rise | bstop_evt) begin
            next_arm = 1'b0;
         end else if (top_rise & ~lclk) begin
            next_arm = 1'b1;
         end
         byte_evt = clk_fall & ~start_evt & ~sstop_evt;
      end else if (sel) begin
         next_bit_cnt = '0;
         next_sh_in = '0;
         bstop_evt = sel_rise;
      end else begin
         start_evt = sel_fall;
         if (clk_fall) begin
            next_sh_in = {sh_in[6:0], top};
            next_bit_cnt = bit_cnt + 3'h1;
            byte_evt = bit_cnt == `RHW_LAST_BIT;
         end
         byte_val = {sh_in[6:0], top};
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         serial <= 1'b0;
         locked <= 1'b0;
         arm <= 1'b0;
         sh_in <= '0;
         bit_cnt <= '0;
      end else begin
         serial <= next_serial;
         locked <= next_locked;
         arm <= next_arm;
         sh_in <= next_sh_in;
         bit_cnt <= next_bit_cnt;
      end
   end

   // Word decoder state
   rhw_state_t state, next_state;
   rhw_loc_t loc, next_loc;
   logic rd_mode, halt, next_rd_mode, next_halt;
   logic n_wr, n_cmd, n_rd, n_push, n_dexit;
   rhw_wr_t n_wr_val;
   logic [4:0] n_code;
   rhw_loc_t adv;
   logic deep, q_in_ready, q_fifo_valid, q_pop, n_ovf;
   logic [7:0] q_fifo_data;

   function automatic logic is_deep(input logic [4:0] a);
      is_deep = (a == `RHW_ADR_DEEP_FIRST) | (a >= `RHW_ADR_DEEP_LO && a <= `RHW_ADR_DEEP_HI);
   endfunction : is_deep

   // Burst advance, deep bytes first, halt at barrier 13
   always_comb begin
      deep = is_deep(loc.addr);
      adv = loc;
      if (loc.addr == `RHW_ADR_QUEUE) begin
         adv = loc;
      end else if (deep && loc.idx != `RHW_DEEP_LAST) begin
         adv.idx = loc.idx + 2'h1;
      end else begin
         adv.addr = loc.addr + 5'h1;
         adv.idx = '0;
      end
   end

   always_comb begin
      next_state = state;
      next_loc = loc;
      next_rd_mode = rd_mode;
      next_halt = halt;
      n_wr = 1'b0;
      n_cmd = 1'b0;
      n_rd = 1'b0;
      n_push = 1'b0;
      n_dexit = sstop_evt;
      n_code = cmd_code_out;
      n_wr_val = '{loc: loc, data: byte_val};
      if (start_evt) begin
         next_state = RHW_WORD;
         next_halt = 1'b0;
      end else if (sstop_evt | bstop_evt) begin
         next_state = RHW_IDLE;
      end else if (byte_evt) begin
         case (state)
            RHW_WORD: begin
               if (byte_val[`RHW_BIT_CMD]) begin
                  n_cmd = 1'b1;
                  n_code = byte_val[4:0];
               end else begin
                  next_loc = '{addr: byte_val[4:0], idx: 2'h0};
                  next_rd_mode = byte_val[`RHW_BIT_RD];
                  // Deep registers and queue refuse single access
                  next_halt = ~byte_val[`RHW_BIT_BURST]
                     & (is_deep(byte_val[4:0]) | byte_val[4:0] == `RHW_ADR_QUEUE);
                  n_rd = byte_val[`RHW_BIT_RD] & ~next_halt;
                  next_state = byte_val[`RHW_BIT_BURST] ? RHW_BURST : RHW_SGL;
               end
            end
            RHW_SGL: begin
               n_wr = ~rd_mode & ~halt;
               next_state = RHW_WORD;
            end
            RHW_BURST: begin
               if (!halt) begin
                  n_push = ~rd_mode & (loc.addr == `RHW_ADR_QUEUE);
                  n_wr = ~rd_mode & (loc.addr != `RHW_ADR_QUEUE);
                  // End of 12 may not roll into 13
                  next_halt = (loc.addr == `RHW_ADR_DEEP_FIRST) & (loc.idx == `RHW_DEEP_LAST);
                  next_loc = adv;
                  n_rd = rd_mode & ~next_halt;
               end
            end
            default: next_state = state;
         endcase
      end
      n_ovf = (queue_overflow_out & ~start_evt) | (n_push & ~q_in_ready);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= RHW_IDLE;
         loc <= '0;
         rd_mode <= 1'b0;
         halt <= 1'b0;
         wr_strobe_out <= 1'b0;
         wr_out <= '0;
         cmd_strobe_out <= 1'b0;
         cmd_code_out <= '0;
         rd_req_out <= 1'b0;
         rd_loc_out <= '0;
         direct_exit_out <= 1'b0;
         queue_overflow_out <= 1'b0;
      end else begin
         state <= next_state;
         loc <= next_loc;
         rd_mode <= next_rd_mode;
         halt <= next_halt;
         wr_strobe_out <= n_wr;
         wr_out <= n_wr_val;
         cmd_strobe_out <= n_cmd;
         cmd_code_out <= n_code;
         rd_req_out <= n_rd;
         rd_loc_out <= next_loc;
         direct_exit_out <= n_dexit;
         queue_overflow_out <= n_ovf;
      end
   end

   // Queue bytes buffered; full fifo drops and flags overflow
   rhw_fifo #(.WIDTH(8), .DEPTH(QUEUE_DEPTH)) u_fifo (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_valid_in(n_push),
      .in_ready_out(q_in_ready),
      .in_data_in(byte_val),
      .out_valid_out(q_fifo_valid),
      .out_ready_in(q_pop),
      .out_data_out(q_fifo_data)
   );

   // Registered output stage of the queue path
   logic n_qv;
   logic [7:0] n_qd;
   always_comb begin
      q_pop = ~queue_valid_out | queue_ready_in;
      n_qv = q_pop ? q_fifo_valid : queue_valid_out;
      n_qd = (q_pop & q_fifo_valid) ? q_fifo_data : queue_data_out;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         queue_valid_out <= 1'b0;
         queue_data_out <= '0;
         queue_space_out <= 1'b1;
      end else begin
         queue_valid_out <= n_qv;
         queue_data_out <= n_qd;
         queue_space_out <= q_in_ready;
      end
   end

   // Read byte and pin drivers
   logic [7:0] rd_sh, next_rd_sh, n_bus, n_oe_n;
   logic rd_phase;
   always_comb begin
      rd_phase = rd_mode & ~halt & (state == RHW_SGL || state == RHW_BURST);
      next_rd_sh = rd_sh;
      n_bus = rd_sh;
      n_oe_n = 8'hff;
      if (rd_req_out) begin
         next_rd_sh = rd_data_in;
      end
      if (!serial) begin
         if (locked && rd_phase && lclk) begin
            n_oe_n = 8'h00;
         end
      end else begin
         n_bus = bus_out;
         if (rd_phase && clk_rise && !sel && !rd_req_out) begin
            n_bus[`RHW_PIN_SDO] = rd_sh[7];
            next_rd_sh = {rd_sh[6:0], 1'b0};
         end
         n_oe_n[`RHW_PIN_SDO] = ~(rd_phase & ~sel);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_sh <= '0;
         bus_out <= '0;
         bus_oe_n_out <= 8'hff;
         serial_mode_out <= 1'b0;
         mode_locked_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         rd_sh <= next_rd_sh;
         bus_out <= n_bus;
         bus_oe_n_out <= n_oe_n;
         serial_mode_out <= serial;
         mode_locked_out <= locked;
         busy_out <= state != RHW_IDLE;
      end
   end
endmodule : rhw_host_port

// *** core/rhw_map.svh ***
`ifndef RHW_MAP_SVH
`define RHW_MAP_SVH
// Host word layout
`define RHW_BIT_CMD 7
`define RHW_BIT_RD 6
`define RHW_BIT_BURST 5
// Address map points
`define RHW_ADR_DEEP_FIRST 5'h12
`define RHW_ADR_DEEP_LO 5'h14
`define RHW_ADR_DEEP_HI 5'h17
`define RHW_ADR_TXLEN0 5'h1d
`define RHW_ADR_TXLEN1 5'h1e
`define RHW_ADR_QUEUE 5'h1f
`define RHW_DEEP_LAST 2'h2
// Serial framing and pin roles
`define RHW_LAST_BIT 3'h7
`define RHW_PIN_SDI 7
`define RHW_PIN_SDO 6
`define RHW_PIN_SEL 4
`endif

// *** core/rhw_pkg.sv ***
package rhw_pkg;
   // Decoder states, Gray along idle-word-single-burst
   typedef enum logic [1:0] {
      RHW_IDLE = 2'h0,
      RHW_WORD = 2'h1,
      RHW_SGL = 2'h3,
      RHW_BURST = 2'h2
   } rhw_state_t;
   // Register location: address plus byte of a deep register
   typedef struct packed {
      logic [4:0] addr;
      logic [1:0] idx;
   } rhw_loc_t;
   // Register write carrier
   typedef struct packed {
      rhw_loc_t loc;
      logic [7:0] data;
   } rhw_wr_t;
endpackage : rhw_pkg

// *** test/rhw_host_props.sv ***
`timescale 1ns/10ps
module rhw_host_props (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] bus_in,
   input wire logic [7:0] bus_oe_n_out,
   input wire logic wr_strobe_out,
   input wire rhw_pkg::rhw_wr_t wr_out,
   input wire logic cmd_strobe_out,
   input wire logic direct_exit_out,
   input wire logic serial_mode_out,
   input wire logic mode_locked_out,
   input wire logic busy_out
);
   import rhw_pkg::*;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   // One word is either a command or an address
   property p_one_kind;
      !(wr_strobe_out && cmd_strobe_out);
   endproperty
   a_one_kind: assert property (p_one_kind)
      else $error("write and command strobes together");
   // Only deep registers see byte indexes above zero
   property p_deep_idx;
      wr_strobe_out && wr_out.loc.idx != 2'h0 |-> wr_out.loc.idx <= 2'h2 &&
         (wr_out.loc.addr == 5'h12 || (wr_out.loc.addr >= 5'h14 && wr_out.loc.addr <= 5'h17));
   endproperty
   a_deep_idx: assert property (p_deep_idx)
      else $error("byte index on a plain register");
   property p_wr_pulse;
      wr_strobe_out |=> !wr_strobe_out;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe longer than a cycle");
   // Serial mode may only drive the output line
   property p_ser_pins;
      serial_mode_out |-> (bus_oe_n_out | 8'h40) == 8'hff;
   endproperty
   a_ser_pins: assert property (p_ser_pins)
      else $error("serial mode drives a wrong line");
   property p_ser_reset;
      serial_mode_out && bus_in[4] [*6] |-> !busy_out && bus_oe_n_out[6];
   endproperty
   a_ser_reset: assert property (p_ser_reset)
      else $error("serial port active while deselected");
   property p_ser_end;
      serial_mode_out && $rose(bus_in[4]) |-> ##[1:6] !busy_out;
   endproperty
   a_ser_end: assert property (p_ser_end)
      else $error("select rise did not end transfer");
   // Parallel reads drive all eight lines or none
   property p_par_out;
      mode_locked_out && !serial_mode_out && bus_oe_n_out != 8'hff |-> bus_oe_n_out == 8'h00;
   endproperty
   a_par_out: assert property (p_par_out)
      else $error("partial parallel drive");
   property p_mode_fixed;
      mode_locked_out |=> mode_locked_out && $stable(serial_mode_out);
   endproperty
   a_mode_fixed: assert property (p_mode_fixed)
      else $error("interface type changed");
   property p_stop_idle;
      direct_exit_out |=> !busy_out && !serial_mode_out;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("busy after single stop");
endmodule : rhw_host_props
bind rhw_host_port rhw_host_props u_props (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in),
   .bus_oe_n_out(bus_oe_n_out), .wr_strobe_out(wr_strobe_out), .wr_out(wr_out),
   .cmd_strobe_out(cmd_strobe_out), .direct_exit_out(direct_exit_out),
   .serial_mode_out(serial_mode_out), .mode_locked_out(mode_locked_out), .busy_out(busy_out));

// *** test/rhw_host_model.sv ***
`timescale 1ns/10ps
module rhw_host_model (
   input wire logic clk_in,
   input wire logic [7:0] dev_out_in,
   input wire logic [7:0] dev_oe_n_in,
   output logic link_clk_out,
   output logic [7:0] line_out
);
   logic [7:0] drv = 8'h10;
   logic in_frame = 1'b0;
   logic tgl = 1'b0;
   initial link_clk_out = 1'b0;
   // Released output toggles so stale data never passes
   always @(negedge clk_in) tgl <= ~tgl;
   always_comb begin
      line_out = drv;
      if (in_frame) line_out[6] = tgl;
      for (int i = 0; i < 8; i++) if (!dev_oe_n_in[i]) line_out[i] = dev_out_in[i];
   end
   task automatic wait_c(input int n);
      repeat (n) @(negedge clk_in);
   endtask : wait_c
   // Long guard so select rise trails the last fall by 350 ns
   task automatic frame(input logic on);
      wait_c(12);
      drv[4] = !on;
      in_frame = on;
      wait_c(4);
   endtask : frame
   // Clock stands still outside words
   task automatic word(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         drv[7] = tx[i];
         wait_c(1);
         link_clk_out = 1'b1;
         wait_c(5);
         rx[i] = line_out[6];
         link_clk_out = 1'b0;
         wait_c(2);
      end
   endtask : word
endmodule : rhw_host_model

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
   import rhw_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic chip_enable_in = 1'b0;
   logic queue_ready_in = 1'b0;
   logic link_clk, wr_stb, cmd_stb, q_valid, ovf, serial, locked;
   logic rd_req, q_space, dexit, busy;
   int rd_cnt = 0;
   int dx_cnt = 0;
   logic [7:0] line, bus_out, oe_n, rd_data, q_data, rx;
   logic [4:0] cmd_code;
   rhw_loc_t rd_loc;
   rhw_wr_t wr;
   rhw_wr_t wr_log[$];
   logic [4:0] cmd_log[$];
   logic [7:0] q_log[$];
   int failures = 0;
   int cmp_count = 0;
   always #12.5 clk_in = ~clk_in;
   // Read data encodes its location, so order slips show
   assign rd_data = {1'b1, rd_loc};
   rhw_host_port #(.QUEUE_DEPTH(4)) dut (.clk_in(clk_in), .rst_in(rst_in),
      .chip_enable_in(chip_enable_in), .link_clk_in(link_clk), .bus_in(line),
      .bus_out(bus_out), .bus_oe_n_out(oe_n), .wr_strobe_out(wr_stb), .wr_out(wr),
      .cmd_strobe_out(cmd_stb), .cmd_code_out(cmd_code), .rd_req_out(rd_req),
      .rd_loc_out(rd_loc), .rd_data_in(rd_data), .queue_valid_out(q_valid),
      .queue_data_out(q_data), .queue_ready_in(queue_ready_in), .queue_space_out(q_space),
      .queue_overflow_out(ovf), .direct_exit_out(dexit), .serial_mode_out(serial),
      .mode_locked_out(locked), .busy_out(busy));
   rhw_host_model u_host (.clk_in(clk_in), .dev_out_in(bus_out), .dev_oe_n_in(oe_n),
      .link_clk_out(link_clk), .line_out(line));
   // Log everything handed to the register side
   always @(posedge clk_in) begin
      if (wr_stb === 1'b1 && wr.loc.addr !== 5'h1f) wr_log.push_back(wr);
      if (cmd_stb === 1'b1) cmd_log.push_back(cmd_code);
      if (rd_req === 1'b1) rd_cnt++;
      if (dexit === 1'b1) dx_cnt++;
      if (q_valid === 1'b1 && queue_ready_in === 1'b1) q_log.push_back(q_data);
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic finish_test;
      if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic send(input logic [7:0] b);
      u_host.word(b, rx);
   endtask : send
   task automatic exp_wr(input rhw_wr_t e);
      chk({1'b0, wr_log.pop_front()}, {1'b0, e});
   endtask : exp_wr
   task automatic lock_mode(input logic exp);
      for (int i = 0; i < 20 && locked !== 1'b1; i++) @(negedge clk_in);
      chk(serial, exp);
   endtask : lock_mode
   task automatic t_single;
      u_host.frame(1'b1);
      send(8'h01); send(8'h55); send(8'h03); send(8'haa); send(8'h12); send(8'h77);
      u_host.frame(1'b0);
      exp_wr({5'h01, 2'h0, 8'h55});
      exp_wr({5'h03, 2'h0, 8'haa});
      chk(16'(wr_log.size()), 16'h0);
      chk({15'h0, busy}, 16'h0);
   endtask : t_single
   // Command then burst; fourth byte must not cross into 13
   task automatic t_burst;
      u_host.frame(1'b1);
      send(8'h96); send(8'h32); send(8'h11); send(8'h22); send(8'h33); send(8'h44);
      u_host.frame(1'b0);
      chk({11'h0, cmd_log.pop_front()}, 16'h0016);
      exp_wr({5'h12, 2'h0, 8'h11});
      exp_wr({5'h12, 2'h1, 8'h22});
      exp_wr({5'h12, 2'h2, 8'h33});
      chk(16'(wr_log.size()), 16'h0);
   endtask : t_burst
   // Transmit stream; fifo plus output stage hold five, sixth byte drops
   task automatic t_queue;
      u_host.frame(1'b1);
      send(8'h8f); send(8'h90); send(8'h3d); send(8'h00); send(8'h06);
      for (int i = 0; i < 6; i++) send(8'ha0 + 8'(i));
      u_host.frame(1'b0);
      chk({11'h0, cmd_log.pop_front()}, 16'h000f);
      chk({11'h0, cmd_log.pop_front()}, 16'h0010);
      exp_wr({5'h1d, 2'h0, 8'h00});
      exp_wr({5'h1e, 2'h0, 8'h06});
      chk({15'h0, ovf}, 16'h1);
      chk({15'h0, q_space}, 16'h0);
      queue_ready_in = 1'b1;
      repeat (12) @(negedge clk_in);
      chk(16'(q_log.size()), 16'h5);
      for (int i = 0; i < 5; i++) chk({8'h0, q_log.pop_front()}, 16'h00a0 + 16'(i));
      chk({15'h0, q_space}, 16'h1);
   endtask : t_queue
   // Single read, then burst read of a deep register, in one frame
   task automatic t_read;
      rd_cnt = 0;
      u_host.frame(1'b1);
      send(8'h41);
      send(8'h00);
      chk({8'h0, rx}, 16'h0084);
      send(8'h72);
      for (int i = 0; i < 3; i++) begin
         send(8'h00);
         chk({8'h0, rx}, 16'h00c8 + 16'(i));
      end
      u_host.frame(1'b0);
      chk(16'(rd_cnt), 16'h4);
      chk(16'(dx_cnt), 16'h0);
      chk({15'h0, busy}, 16'h0);
   endtask : t_read
   initial begin
      repeat (8) @(negedge clk_in);
      rst_in = 1'b0;
      chip_enable_in = 1'b1;
      lock_mode(1'b1);
      t_single;
      t_burst;
      t_queue;
      t_read;
      rst_in = 1'b1;
      chip_enable_in = 1'b0;
      u_host.drv = 8'h00;
      repeat (8) @(negedge clk_in);
      rst_in = 1'b0;
      chip_enable_in = 1'b1;
      lock_mode(1'b0);
      finish_test;
   end
   // Run needs about 2000 cycles
   initial begin
      #400000;
      failures++;
      finish_test;
   end
endmodule : testbench
